/* core/eag_map.svh */
// constants and address map of the effective address generator
`ifndef EAG_MAP_SVH
`define EAG_MAP_SVH
`define EAG_X_WL 11
`define EAG_X_SCH 10
`define EAG_X_SCL 9
`define EAG_X_BS 7
`define EAG_X_IS 6
`define EAG_X_BDH 5
`define EAG_X_BDL 4
`define EAG_X_IIH 2
`define EAG_X_IIL 0
`define EAG_SZ_RSV 2'b00
`define EAG_SZ_NUL 2'b01
`define EAG_SZ_WRD 2'b10
`define EAG_SZ_LNG 2'b11
`define EAG_II_NONE 3'b000
`define EAG_II_RSV 3'b100
`define EAG_DEC_B 32'h0000_0001
`define EAG_DEC_W 32'h0000_0002
`define EAG_DEC_L 32'h0000_0004
`define EAG_A_CTRL 12'h000
`define EAG_A_STAT 12'h004
`define EAG_A_LEA 12'h008
`define EAG_A_CNT 12'h00c
`define EAG_CTRL_RST 32'h0000_0071
`define EAG_CTRL_MSK 32'h0000_0071
`define EAG_C_EN 0
`define EAG_C_SPH 6
`define EAG_C_SPL 4
`endif

/* core/eag_pkg.sv */
// types shared by the effective address generator
package eag_pkg;
  typedef enum logic [2:0] {
    EAG_M_PREDEC = 3'b000,
    EAG_M_DISP = 3'b001,
    EAG_M_IDX8 = 3'b010,
    EAG_M_FULL = 3'b011,
    EAG_M_PCDISP = 3'b101,
    EAG_M_PCIDX8 = 3'b110,
    EAG_M_PCFULL = 3'b111
  } eag_mode_t;
  typedef enum logic [1:0] {
    EAG_S_BYTE = 2'b00,
    EAG_S_WORD = 2'b01,
    EAG_S_LONG = 2'b10,
    EAG_S_COP = 2'b11
  } eag_size_t;
  typedef enum logic {
    EAG_ST_IDLE = 1'b0,
    EAG_ST_FETCH = 1'b1
  } eag_state_t;
endpackage

/* core/eag_core.sv */
// effective address datapath with pointer fetch and apb control
`timescale 1ns/1ps
`include "eag_map.svh"
module eag_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  output logic req_ready,
  input wire eag_pkg::eag_mode_t req_mode,
  input wire eag_pkg::eag_size_t req_size,
  input wire logic [7:0] req_cop_len,
  input wire logic [2:0] req_areg,
  input wire logic req_write,
  input wire logic [31:0] base_address_register,
  input wire logic [31:0] pc_value,
  input wire logic [15:0] ext_word,
  input wire logic [31:0] base_displacement,
  input wire logic [31:0] outer_displacement,
  input wire logic [31:0] index_register_operand,
  output logic ptr_req,
  output logic [31:0] ptr_addr,
  output logic ptr_program_space,
  input wire logic ptr_ack,
  input wire logic ptr_berr,
  input wire logic [31:0] ptr_data,
  output logic ea_valid,
  output logic [31:0] ea_addr,
  output logic ea_program_space,
  output logic ea_write_fault,
  output logic ea_reserved,
  output logic ea_bus_error
);
  import eag_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] sxw(input logic [15:0] w);
    return {{16{w[15]}}, w};
  endfunction

  // displacement by size code, null and reserved add nothing
  function automatic logic [31:0] dsel(input logic [1:0] sz,
                                       input logic [31:0] raw);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (sz == `EAG_SZ_WRD) begin
      r = sxw(raw[15:0]);
    end else if (sz == `EAG_SZ_LNG) begin
      r = raw;
    end
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  eag_state_t state_reg, state_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [1:0] stat_reg, stat_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] add_reg, add_next;
  logic wf_reg, wf_next;
  logic ready_next, preq_next, pps_next;
  logic [31:0] paddr_next;
  logic ev_next, eps_next, ewf_next, ersv_next, eberr_next;
  logic [31:0] eaddr_next;
  logic prdy_next, perr_next;
  logic [31:0] prd_next;

  // ----------------------------------------
  // extension word decode
  // ----------------------------------------
  wire take = ce & req_valid & req_ready;
  wire is_pc = req_mode[2];
  wire is_full = (req_mode == EAG_M_FULL) | (req_mode == EAG_M_PCFULL);
  wire is_idx8 = (req_mode == EAG_M_IDX8) | (req_mode == EAG_M_PCIDX8);
  wire is_disp = (req_mode == EAG_M_DISP) | (req_mode == EAG_M_PCDISP);
  wire bs = ext_word[`EAG_X_BS];
  wire isup = ext_word[`EAG_X_IS];
  wire [1:0] bdsz = ext_word[`EAG_X_BDH:`EAG_X_BDL];
  wire [2:0] iis = ext_word[`EAG_X_IIH:`EAG_X_IIL];
  wire [1:0] scl = ext_word[`EAG_X_SCH:`EAG_X_SCL];
  wire [2:0] sp_num = ctrl_reg[`EAG_C_SPH:`EAG_C_SPL];
  wire en = ctrl_reg[`EAG_C_EN];

  wire rsv = is_full & ((bdsz == `EAG_SZ_RSV) |
             (~isup & (iis == `EAG_II_RSV)) | (isup & iis[2]));
  wire ind = is_full & (iis != `EAG_II_NONE) & ~rsv;
  wire post = iis[2] & ~isup;

  // ----------------------------------------
  // operand terms
  // ----------------------------------------
  // index sized by the word/long bit
  wire [31:0] idx_ext = ext_word[`EAG_X_WL] ? index_register_operand :
                        sxw(index_register_operand[15:0]);
  wire [31:0] idx_sc = idx_ext << scl;
  wire [31:0] idx_in = (is_full & isup) ? 32'h0000_0000 : idx_sc;
  // pc stands for the extension word address
  wire [31:0] base_raw = is_pc ? pc_value : base_address_register;
  // suppressed base or pc is zero
  wire [31:0] base_v = (is_full & bs) ? 32'h0000_0000 : base_raw;
  wire [31:0] bd_v = dsel(bdsz, base_displacement);
  wire [31:0] od_v = dsel(iis[1:0], outer_displacement);

  // byte stack pointer keeps even alignment
  wire sp_byte = (req_areg == sp_num);
  wire [31:0] dec = (req_size == EAG_S_BYTE) ?
                    (sp_byte ? `EAG_DEC_W : `EAG_DEC_B) :
                    (req_size == EAG_S_WORD) ? `EAG_DEC_W :
                    (req_size == EAG_S_LONG) ? `EAG_DEC_L :
                    {24'h00_0000, req_cop_len};

  // full format sum, index left out when post
  wire [31:0] inter = base_v + bd_v + (post ? 32'h0000_0000 : idx_in);
  // after the fetch: index when post, plus outer
  wire [31:0] post_add = (post ? idx_in : 32'h0000_0000) + od_v;

  wire [31:0] ea_dir = (req_mode == EAG_M_PREDEC) ? base_raw - dec :
                       is_disp ? base_raw + sxw(ext_word) :
                       is_idx8 ? base_raw + sxw({{8{ext_word[7]}}, ext_word[7:0]}) + idx_sc :
                       inter;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // stall until the pointer answers
  wire fetch_st = (state_reg == EAG_ST_FETCH);
  wire fdone = ce & fetch_st & (ptr_ack | ptr_berr);
  wire go_fetch = take & ind;
  wire done_now = take & ~ind;
  assign state_next = go_fetch ? EAG_ST_FETCH :
                      fdone ? EAG_ST_IDLE : state_reg;
  assign ready_next = en & (state_next == EAG_ST_IDLE);
  assign preq_next = (state_next == EAG_ST_FETCH);
  assign paddr_next = go_fetch ? inter : ptr_addr;
  assign add_next = go_fetch ? post_add : add_reg;
  // program space and write refusal held over the fetch
  assign pps_next = take ? is_pc : ptr_program_space;
  assign wf_next = take ? (is_pc & req_write) : wf_reg;

  // results; a bus error reports the pointer address
  assign ev_next = done_now | fdone;
  assign eaddr_next = done_now ? ea_dir :
                      ~fdone ? ea_addr :
                      ptr_berr ? ptr_addr : ptr_data + add_reg;
  assign eps_next = done_now ? is_pc : fdone ? ptr_program_space : ea_program_space;
  assign ewf_next = done_now ? (is_pc & req_write) : fdone ? wf_reg : ea_write_fault;
  assign ersv_next = done_now ? rsv : fdone ? 1'b0 : ea_reserved;
  // bus error passed with the completion
  assign eberr_next = done_now ? 1'b0 : fdone ? ptr_berr : ea_bus_error;

  // datapath flops, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= EAG_ST_IDLE;
      req_ready <= 1'b0;
      ptr_req <= 1'b0;
      ptr_addr <= 32'h0000_0000;
      ptr_program_space <= 1'b0;
      add_reg <= 32'h0000_0000;
      wf_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      req_ready <= ready_next;
      ptr_req <= preq_next;
      ptr_addr <= paddr_next;
      ptr_program_space <= pps_next;
      add_reg <= add_next;
      wf_reg <= wf_next;
    end
  end

  // result flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_valid <= 1'b0;
      ea_addr <= 32'h0000_0000;
      ea_program_space <= 1'b0;
      ea_write_fault <= 1'b0;
      ea_reserved <= 1'b0;
      ea_bus_error <= 1'b0;
    end else if (ce) begin
      ea_valid <= ev_next;
      ea_addr <= eaddr_next;
      ea_program_space <= eps_next;
      ea_write_fault <= ewf_next;
      ea_reserved <= ersv_next;
      ea_bus_error <= eberr_next;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // no wait state: pready rises in the first access cycle
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire hit_c = (paddr == `EAG_A_CTRL);
  wire hit_s = (paddr == `EAG_A_STAT);
  wire hit_l = (paddr == `EAG_A_LEA);
  wire hit_n = (paddr == `EAG_A_CNT);
  wire hit = hit_c | hit_s | hit_l | hit_n;
  wire [31:0] rmux = hit_c ? ctrl_reg :
                     hit_s ? {29'h0, stat_reg, fetch_st} :
                     hit_l ? ea_addr :
                     hit_n ? cnt_reg : 32'h0000_0000;
  wire [1:0] st_set = {ersv_next & done_now, fdone & ptr_berr};
  wire [1:0] st_clr = (wr & hit_s) ? pwdata[2:1] : 2'b00;
  assign prdy_next = setup;
  assign prd_next = setup ? rmux : prdata;
  assign perr_next = setup ? ~hit : pslverr;
  assign ctrl_next = (wr & hit_c) ? (pwdata & `EAG_CTRL_MSK) : ctrl_reg;
  // sticky flags, a new event beats the write-one clear
  assign stat_next = (stat_reg & ~st_clr) | st_set;
  assign cnt_next = ev_next ? cnt_reg + 32'h0000_0001 : cnt_reg;

  // register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `EAG_CTRL_RST;
      stat_reg <= 2'b00;
      cnt_reg <= 32'h0000_0000;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      cnt_reg <= cnt_next;
      pready <= prdy_next;
      prdata <= prd_next;
      pslverr <= perr_next;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_predec_long;
    take && req_mode == EAG_M_PREDEC && req_size == EAG_S_LONG |=>
      ea_valid && ea_addr == $past(base_address_register) - 32'h4;
  endproperty
  a_predec_long: assert property (p_predec_long) else $error("long predecrement wrong");

  property p_sp_byte;
    take && req_mode == EAG_M_PREDEC && req_size == EAG_S_BYTE &&
      req_areg == sp_num |=> ea_addr == $past(base_address_register) - 32'h2;
  endproperty
  a_sp_byte: assert property (p_sp_byte) else $error("stack byte step not two");

  property p_cop;
    take && req_mode == EAG_M_PREDEC && req_size == EAG_S_COP |=>
      ea_addr == $past(base_address_register) - {24'h0, $past(req_cop_len)};
  endproperty
  a_cop: assert property (p_cop) else $error("coprocessor step wrong");

  property p_disp;
    take && req_mode == EAG_M_DISP |=> ea_addr ==
      $past(base_address_register) + {{16{$past(ext_word[15])}}, $past(ext_word)};
  endproperty
  a_disp: assert property (p_disp) else $error("displacement sum wrong");

  property p_zero;
    take && req_mode == EAG_M_FULL && bs && isup &&
      bdsz == `EAG_SZ_NUL && iis == `EAG_II_NONE |=> ea_valid && ea_addr == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("empty full format not zero");

  property p_pc_space;
    take && is_pc |=> ##[0:300] ea_valid && ea_program_space &&
      ea_write_fault == $past(req_write, 1);
  endproperty
  a_pc_space: assert property (p_pc_space) else $error("pc reference not program space");

  property p_stall;
    ce && fetch_st && !ptr_ack && !ptr_berr |=> !ea_valid && ptr_req;
  endproperty
  a_stall: assert property (p_stall) else $error("completed before pointer");

  property p_berr;
    ce && fetch_st && ptr_berr |=> ea_valid && ea_bus_error && !ptr_req;
  endproperty
  a_berr: assert property (p_berr) else $error("pointer bus error lost");

  property p_ind_req;
    take && ind |=> ptr_req && !ea_valid && ptr_program_space == $past(is_pc);
  endproperty
  a_ind_req: assert property (p_ind_req) else $error("indirect fetch not requested");

  property p_pre_addr;
    take && ind && !post && !is_pc && !bs && !isup && bdsz == `EAG_SZ_NUL |=>
      ptr_addr == $past(base_address_register) + $past(idx_sc);
  endproperty
  a_pre_addr: assert property (p_pre_addr) else $error("preindexed pointer address wrong");

  // short index form: base, low byte and scaled index
  property p_idx8;
    take && req_mode == EAG_M_IDX8 |=> ea_valid &&
      ea_addr == $past(base_address_register) + $past(idx_sc) +
      {{24{$past(ext_word[7])}}, $past(ext_word[7:0])};
  endproperty
  a_idx8: assert property (p_idx8) else $error("short index sum wrong");

  // reserved codes finish at once, no pointer fetch
  property p_rsv;
    take && rsv |=> ea_valid && ea_reserved && !ptr_req;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code not flagged");

  // suppressed pc with nothing else still marks program space
  property p_zpc;
    take && req_mode == EAG_M_PCFULL && bs && isup && bdsz == `EAG_SZ_NUL &&
      iis == `EAG_II_NONE |=> ea_addr == 32'h0 && ea_program_space;
  endproperty
  a_zpc: assert property (p_zpc) else $error("suppressed pc wrong");

  // pointer bus error leaves its sticky status bit set
  property p_stat_berr;
    fdone && ptr_berr |=> stat_reg[0];
  endproperty
  a_stat_berr: assert property (p_stat_berr) else $error("bus error status lost");

  c_fetch: cover property (take && ind ##[1:20] fdone && !ptr_berr);
  c_berr: cover property (fetch_st && ptr_berr && ce);
  c_pc_post: cover property (take && ind && post && is_pc);
  c_apb_wr: cover property (wr && hit_c);
  c_rsv: cover property (take && rsv);
endmodule

/* tb/eag_fetch_model.sv */
// pointer fetch responder standing in for the operand bus logic
`timescale 1ns/1ps
module eag_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ptr_req,
  input wire logic [31:0] ptr_addr,
  input wire logic [3:0] lag,
  input wire logic fault,
  output logic ptr_ack,
  output logic ptr_berr,
  output logic [31:0] ptr_data
);
  logic [3:0] cnt;
  logic done;
  // -----------------------------------------
  // answer one long-word read per request
  // -----------------------------------------
  // answer the long-word read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      done <= 1'b0;
      ptr_ack <= 1'b0;
      ptr_berr <= 1'b0;
      ptr_data <= 32'h0;
    end else begin
      ptr_ack <= 1'b0;
      ptr_berr <= 1'b0;
      ptr_data <= ~ptr_data; // stale data keeps moving, never a steady guess
      if (!ptr_req) begin
        cnt <= 4'h0;
        done <= 1'b0;
      end else if (!done) begin
        if (cnt == lag) begin
          done <= 1'b1;
          ptr_ack <= !fault;
          // bus error only when the bench commands it
          ptr_berr <= fault;
          ptr_data <= ptr_addr ^ 32'h5a00_0000;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

/* tb/eag_core_test.sv */
// self-checking bench for the effective address generator
`timescale 1ns/1ps
`include "eag_map.svh"
module eag_core_test;
  import eag_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, req_write;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, base_address_register, pc_value, base_displacement;
  logic [31:0] outer_displacement, index_register_operand, ptr_addr, ptr_data, ea_addr;
  eag_mode_t req_mode;
  eag_size_t req_size;
  logic [7:0] req_cop_len;
  logic [2:0] req_areg;
  logic [15:0] ext_word;
  logic ptr_req, ptr_program_space, ptr_ack, ptr_berr, ea_valid, ea_program_space;
  logic ea_write_fault, ea_reserved, ea_bus_error, fault;
  logic [3:0] lag;
  logic [31:0] ptr_seen, q;
  logic e;
  int failures = 0;
  int samples_checked = 0;
  eag_core eag_core_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .req_mode(req_mode), .req_size(req_size), .req_cop_len(req_cop_len),
    .req_areg(req_areg), .req_write(req_write),
    .base_address_register(base_address_register), .pc_value(pc_value),
    .ext_word(ext_word), .base_displacement(base_displacement),
    .outer_displacement(outer_displacement), .index_register_operand(index_register_operand),
    .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ptr_program_space(ptr_program_space),
    .ptr_ack(ptr_ack), .ptr_berr(ptr_berr), .ptr_data(ptr_data), .ea_valid(ea_valid),
    .ea_addr(ea_addr), .ea_program_space(ea_program_space), .ea_write_fault(ea_write_fault),
    .ea_reserved(ea_reserved), .ea_bus_error(ea_bus_error));
  eag_fetch_model eag_fetch_model_inst (.pclk(pclk), .presetn(presetn), .ptr_req(ptr_req),
    .ptr_addr(ptr_addr), .lag(lag), .fault(fault), .ptr_ack(ptr_ack), .ptr_berr(ptr_berr),
    .ptr_data(ptr_data));
  // ---------------------------
  // clock, verdict and watchdog
  // ---------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a hang anywhere in the sequence ends the run here
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  // the bench's own view of pointer memory contents
  function automatic logic [31:0] mem(input logic [31:0] a);
    return a ^ 32'h5a00_0000;
  endfunction
  // ---------------------------
  // bus and request drivers
  // ---------------------------
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // issue one request and wait for its completion pulse
  task automatic fire(input eag_mode_t m, input logic [15:0] x, input logic [31:0] d, o);
    req_mode <= m;
    ext_word <= x;
    base_displacement <= d;
    outer_displacement <= o;
    req_valid <= 1'b1;
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    ptr_seen = 32'hx;
    for (int n = 0; n < 40; n++) begin
      @(posedge pclk);
      if (ptr_req === 1'b1) ptr_seen = ptr_addr;
      if (ea_valid === 1'b1) break;
    end
  endtask
  // ---------------------------
  // scenarios
  // ---------------------------
  task automatic t_regs();
    apb(1'b0, `EAG_A_CTRL, 32'h0);
    chk_word(q, `EAG_CTRL_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk_bit(e, 1'b1);
    chk_word(q, 32'h0);
    apb(1'b1, `EAG_A_CTRL, 32'h0000_0070);
    repeat (2) @(posedge pclk);
    chk_bit(req_ready, 1'b0);
    apb(1'b1, `EAG_A_CTRL, 32'h0000_0071);
    $display("test regs done");
  endtask
  task automatic t_predec();
    eag_size_t sz [5] = '{EAG_S_BYTE, EAG_S_WORD, EAG_S_LONG, EAG_S_COP, EAG_S_BYTE};
    logic [31:0] dec [5] = '{32'h1, 32'h2, 32'h4, 32'ha, 32'h2};
    for (int k = 0; k < 5; k++) begin
      req_size <= sz[k];
      req_areg <= (k == 4) ? 3'd7 : 3'd3;
      fire(EAG_M_PREDEC, 16'h0, 32'h0, 32'h0);
      chk_word(ea_addr, 32'h0000_1000 - dec[k]);
    end
    $display("test predec done");
  endtask
  task automatic t_direct();
    fire(EAG_M_DISP, 16'h8000, 32'h0, 32'h0);
    chk_word(ea_addr, 32'hffff_9000);
    fire(EAG_M_IDX8, 16'h04fe, 32'h0, 32'h0);
    chk_word(ea_addr, 32'h0000_0fbe);
    fire(EAG_M_FULL, 16'h01d0, 32'h0, 32'h0);
    chk_word(ea_addr, 32'h0);
    fire(EAG_M_FULL, 16'h0f90, 32'h0, 32'h0);
    chk_word(ea_addr, 32'h0007_ff80);
    fire(EAG_M_FULL, 16'h0120, 32'h1234_8000, 32'h0);
    chk_word(ea_addr, 32'hffff_8ff0);
    fire(EAG_M_FULL, 16'h0130, 32'h0010_0000, 32'h0);
    chk_word(ea_addr, 32'h0010_0ff0);
    fire(EAG_M_FULL, 16'h0100, 32'h0, 32'h0);
    chk_bit(ea_reserved, 1'b1);
    $display("test direct done");
  endtask
  task automatic t_indirect();
    lag <= 4'd5;
    fire(EAG_M_FULL, 16'h0122, 32'h20, 32'h8004);
    chk_word(ptr_seen, 32'h1010);
    chk_word(ea_addr, mem(32'h1010) + 32'hffff_8004);
    lag <= 4'd0;
    fire(EAG_M_FULL, 16'h0137, 32'h200, 32'h0001_0000);
    chk_word(ea_addr, mem(32'h1200) + 32'hfff0);
    fire(EAG_M_FULL, 16'h0115, 32'h0, 32'h0);
    chk_word(ea_addr, mem(32'h1000) - 32'h10);
    fire(EAG_M_FULL, 16'h0151, 32'h0, 32'h0);
    chk_word(ea_addr, mem(32'h1000));
    fire(EAG_M_FULL, 16'h0114, 32'h0, 32'h0);
    chk_bit(ea_reserved, 1'b1);
    $display("test indirect done");
  endtask
  task automatic t_pc();
    req_write <= 1'b1;
    fire(EAG_M_PCDISP, 16'h0010, 32'h0, 32'h0);
    chk_word(ea_addr, 32'h0004_0010);
    chk_bit(ea_write_fault, 1'b1);
    req_write <= 1'b0;
    fire(EAG_M_PCIDX8, 16'h02fc, 32'h0, 32'h0);
    chk_word(ea_addr, 32'h0003_ffdc);
    fire(EAG_M_PCFULL, 16'h0190, 32'h0, 32'h0);
    chk_word(ea_addr, 32'hffff_fff0);
    chk_bit(ea_program_space, 1'b1);
    fire(EAG_M_PCFULL, 16'h0121, 32'h40, 32'h0);
    chk_word(ptr_seen, 32'h0004_0030);
    chk_word(ea_addr, mem(32'h0004_0030));
    fire(EAG_M_PCFULL, 16'h0126, 32'h40, 32'h8);
    chk_word(ea_addr, mem(32'h0004_0040) - 32'h8);
    chk_bit(ptr_program_space, 1'b1);
    $display("test pc done");
  endtask
  task automatic t_berr();
    fault <= 1'b1;
    fire(EAG_M_FULL, 16'h0115, 32'h0, 32'h0);
    fault <= 1'b0;
    chk_bit(ea_bus_error, 1'b1);
    chk_word(ea_addr, 32'h1000);
    apb(1'b0, `EAG_A_STAT, 32'h0);
    chk_bit(q[1], 1'b1);
    chk_bit(q[2], 1'b1);
    apb(1'b1, `EAG_A_STAT, 32'h2);
    apb(1'b0, `EAG_A_LEA, 32'h0);
    chk_word(q, 32'h1000);
    $display("test berr done");
  endtask
  // ---------------------------
  // main sequence
  // ---------------------------
  initial begin
    {presetn, psel, penable, pwrite, req_valid, req_write, fault} = 7'h0;
    {paddr, pwdata, ext_word, base_displacement, outer_displacement} = '0;
    req_mode = EAG_M_PREDEC;
    req_size = EAG_S_BYTE;
    req_cop_len = 8'h0a;
    req_areg = 3'd3;
    lag = 4'd0;
    base_address_register = 32'h0000_1000;
    pc_value = 32'h0004_0000;
    index_register_operand = 32'h0000_fff0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_predec();
    t_direct();
    t_indirect();
    t_pc();
    t_berr();
    tally_and_finish();
  end
endmodule
